// File: core/mss_setup_status.sv
// Switch decoding and status indicators for a serial slave front end
//
// Behaviour
// R01 - Node address from hex selector; valid 01 to F7, default 00 invalid.
// R02 - Switches 1-3 pick 38.4k, 19.2k, 9600 or 4800 bit rate.
// R03 - Switches 4-5 pick none, odd or even parity; both OFF invalid.
// R04 - Switch 6 ON selects RTU framing, OFF selects ASCII framing.
// R05 - Alive indicator lights on received data, held ten seconds after.
// R06 - Fault indicator lights on parity, framing, overrun, CRC or LRC error.
// R07 - Transmit indicator follows sending; receive indicator follows arriving characters.
`timescale 1ns/1ps
`include "mss_params.svh"

module mss_setup_status #(
  parameter int unsigned ALIVE_HOLD_CYCLES = `MSS_ALIVE_HOLD_S * `MSS_CLOCK_HZ
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Front panel switches
  input  wire logic [7:0]         addr_switch,
  input  wire logic [5:0]         dip_switch,
  // Receiver and transmitter events
  input  wire logic               rx_char_done,
  input  wire logic               rx_busy,
  input  wire logic               tx_busy,
  input  wire logic               parity_error,
  input  wire logic               framing_error,
  input  wire logic               overrun_error,
  input  wire logic               crc_error,
  input  wire logic               lrc_error,
  input  wire logic               fault_clear,
  // Decoded setup
  output logic [7:0]              node_addr_reg,
  output logic                    addr_valid_reg,
  output mss_pkg::mss_div_t       baud_div_reg,
  output logic                    baud_valid_reg,
  output mss_pkg::mss_parity_e    parity_mode_reg,
  output logic                    parity_valid_reg,
  output mss_pkg::mss_frame_e     frame_mode_reg,
  // Indicators
  output logic                    alive_led_reg,
  output logic                    fault_led_reg,
  output logic                    transmit_activity_indicator_reg,
  output logic                    rx_led_reg
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a >= `MSS_ADDR_MIN) && (a <= `MSS_ADDR_MAX);
  endfunction : addr_ok

  function automatic mss_pkg::mss_div_t baud_div(input logic [2:0] code);
    case (code)
      `MSS_BAUD_CODE_38K4: baud_div = `MSS_DIV_38K4;
      `MSS_BAUD_CODE_19K2: baud_div = `MSS_DIV_19K2;
      `MSS_BAUD_CODE_9600: baud_div = `MSS_DIV_9600;
      `MSS_BAUD_CODE_4800: baud_div = `MSS_DIV_4800;
      default:             baud_div = `MSS_DIV_RESET;
    endcase
  endfunction : baud_div

  function automatic logic baud_ok(input logic [2:0] code);
    baud_ok = (code == `MSS_BAUD_CODE_38K4) || (code == `MSS_BAUD_CODE_19K2) ||
              (code == `MSS_BAUD_CODE_9600) || (code == `MSS_BAUD_CODE_4800);
  endfunction : baud_ok

  function automatic mss_pkg::mss_parity_e parity_sel(input logic odd_sw, input logic even_sw);
    case ({odd_sw, even_sw})
      2'h3:    parity_sel = mss_pkg::MSS_PARITY_NONE;
      2'h1:    parity_sel = mss_pkg::MSS_PARITY_ODD;
      2'h2:    parity_sel = mss_pkg::MSS_PARITY_EVEN;
      default: parity_sel = mss_pkg::MSS_PARITY_BAD;
    endcase
  endfunction : parity_sel

  logic [2:0] baud_code;
  logic       any_error;

  assign baud_code = dip_switch[`MSS_SW_BAUD_LSB +: 3];
  assign any_error = parity_error | framing_error | overrun_error | crc_error | lrc_error;

  // ----------------------------------------------------------------
  // Node address
  // ----------------------------------------------------------------
  // Address is passed through even when out of range so firmware can report it
  always_ff @(posedge clock) begin
    if (rst) begin
      node_addr_reg  <= `MSS_ADDR_RESET;
      addr_valid_reg <= 1'b0;
    end else begin
      node_addr_reg  <= addr_switch;
      addr_valid_reg <= addr_ok(addr_switch); // R01
    end
  end

  // ----------------------------------------------------------------
  // Line rate
  // ----------------------------------------------------------------
  // Unlisted switch patterns fall back to 9600 and flag the setting as bad
  always_ff @(posedge clock) begin
    if (rst) begin
      baud_div_reg   <= `MSS_DIV_RESET;
      baud_valid_reg <= 1'b0;
    end else begin
      baud_div_reg   <= baud_div(baud_code); // R02
      baud_valid_reg <= baud_ok(baud_code); // R02
    end
  end

  // ----------------------------------------------------------------
  // Parity and framing
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      parity_mode_reg  <= mss_pkg::MSS_PARITY_NONE;
      parity_valid_reg <= 1'b0;
    end else begin
      parity_mode_reg  <= parity_sel(dip_switch[`MSS_SW_PARITY_ODD],
                                     dip_switch[`MSS_SW_PARITY_EVEN]); // R03
      parity_valid_reg <= dip_switch[`MSS_SW_PARITY_ODD] |
                          dip_switch[`MSS_SW_PARITY_EVEN]; // R03
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      frame_mode_reg <= mss_pkg::MSS_FRAME_RTU;
    end else if (dip_switch[`MSS_SW_FRAME]) begin
      frame_mode_reg <= mss_pkg::MSS_FRAME_RTU; // R04
    end else begin
      frame_mode_reg <= mss_pkg::MSS_FRAME_ASCII; // R04
    end
  end

  // ----------------------------------------------------------------
  // Alive indicator
  // ----------------------------------------------------------------
  logic alive_hold;

  mss_hold_timer #(
    .HOLD_CYCLES (ALIVE_HOLD_CYCLES)
  ) u_alive_timer (
    .clock   (clock),
    .rst     (rst),
    .trigger (rx_char_done),
    .active  (alive_hold)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      alive_led_reg <= 1'b0;
    end else begin
      alive_led_reg <= alive_hold; // R05
    end
  end

  // ----------------------------------------------------------------
  // Fault indicator
  // ----------------------------------------------------------------
  // Sticky so a single bad character is still visible; a new error beats a clear
  always_ff @(posedge clock) begin
    if (rst) begin
      fault_led_reg <= 1'b0;
    end else if (any_error) begin
      fault_led_reg <= 1'b1; // R06
    end else if (fault_clear) begin
      fault_led_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Traffic indicators
  // ----------------------------------------------------------------
  // One-cycle lag only; short frames at 38.4k still show for a full character
  always_ff @(posedge clock) begin
    if (rst) begin
      transmit_activity_indicator_reg <= 1'b0;
      rx_led_reg                      <= 1'b0;
    end else begin
      transmit_activity_indicator_reg <= tx_busy; // R07
      rx_led_reg                      <= rx_busy; // R07
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ADDR_RANGE: assert property (@(posedge clock) disable iff (rst) // R01
    (addr_switch >= 8'h01 && addr_switch <= 8'hf7) |=> addr_valid_reg)
    else $error("Address in range not flagged valid");

  AST_ADDR_ZERO: assert property (@(posedge clock) disable iff (rst) // R01
    (addr_switch == 8'h00 || addr_switch > 8'hf7) |=> !addr_valid_reg)
    else $error("Address out of range flagged valid");

  AST_BAUD_38K4: assert property (@(posedge clock) disable iff (rst) // R02
    (dip_switch[2:0] == 3'h3) |=> (baud_div_reg == 14'h0411) && baud_valid_reg)
    else $error("Switches ON ON OFF did not give 38.4k divider");

  AST_BAUD_4800: assert property (@(posedge clock) disable iff (rst) // R02
    (dip_switch[2:0] == 3'h0) |=> (baud_div_reg == 14'h208d))
    else $error("All OFF did not give 4800 divider");

  AST_PARITY: assert property (@(posedge clock) disable iff (rst) // R03
    (dip_switch[4:3] == 2'h0) |=> !parity_valid_reg &&
                                  (parity_mode_reg == mss_pkg::MSS_PARITY_BAD))
    else $error("Both parity switches OFF not flagged invalid");

  AST_PARITY_ODD: assert property (@(posedge clock) disable iff (rst) // R03
    (dip_switch[4:3] == 2'h2) |=> (parity_mode_reg == mss_pkg::MSS_PARITY_ODD))
    else $error("Switch 4 OFF, 5 ON did not select odd parity");

  AST_FRAME: assert property (@(posedge clock) disable iff (rst) // R04
    dip_switch[5] |=> (frame_mode_reg == mss_pkg::MSS_FRAME_RTU))
    else $error("Switch 6 ON did not select RTU");

  AST_ALIVE: assert property (@(posedge clock) disable iff (rst) // R05
    rx_char_done |-> ##2 alive_led_reg[*2])
    else $error("Alive indicator not lit after reception");

  AST_FAULT_SET: assert property (@(posedge clock) disable iff (rst) // R06
    (crc_error || lrc_error || parity_error || framing_error || overrun_error)
      |=> fault_led_reg)
    else $error("Fault indicator not lit after error");

  AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (rst) // R06
    fault_led_reg && !fault_clear |=> fault_led_reg)
    else $error("Fault indicator dropped without clear");

  AST_TRAFFIC: assert property (@(posedge clock) disable iff (rst) // R07
    (tx_busy && !rx_busy) |=> transmit_activity_indicator_reg && !rx_led_reg)
    else $error("Traffic indicators do not follow activity");

  COV_ALIVE: cover property (@(posedge clock) disable iff (rst)
    rx_char_done ##2 alive_led_reg);
  COV_FAULT_CLEAR: cover property (@(posedge clock) disable iff (rst)
    fault_led_reg && fault_clear ##1 !fault_led_reg);
  COV_ASCII: cover property (@(posedge clock) disable iff (rst)
    frame_mode_reg == mss_pkg::MSS_FRAME_ASCII && parity_valid_reg);

endmodule : mss_setup_status

// File: core/mss_params.svh
// Constants for the serial setup and status front end
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define MSS_CLOCK_HZ        40000000
`define MSS_ALIVE_HOLD_S    10

// ----------------------------------------------------------------
// Node address selector limits
// ----------------------------------------------------------------
`define MSS_ADDR_MIN        8'h01
`define MSS_ADDR_MAX        8'hf7
`define MSS_ADDR_RESET      8'h00

// ----------------------------------------------------------------
// Switch positions in the dip switch word (bit n-1 is switch n, 1 = ON)
// ----------------------------------------------------------------
`define MSS_SW_BAUD_LSB     0
`define MSS_SW_PARITY_ODD   3
`define MSS_SW_PARITY_EVEN  4
`define MSS_SW_FRAME        5

// ----------------------------------------------------------------
// Baud selector codes {sw3, sw2, sw1}
// ----------------------------------------------------------------
`define MSS_BAUD_CODE_38K4  3'h3
`define MSS_BAUD_CODE_19K2  3'h2
`define MSS_BAUD_CODE_9600  3'h1
`define MSS_BAUD_CODE_4800  3'h0

// ----------------------------------------------------------------
// Bit rates, and clock cycles per bit at each rate
// ----------------------------------------------------------------
`define MSS_BAUD_38K4       38400
`define MSS_BAUD_19K2       19200
`define MSS_BAUD_9600       9600
`define MSS_BAUD_4800       4800
`define MSS_DIV_38K4        14'(`MSS_CLOCK_HZ / `MSS_BAUD_38K4)
`define MSS_DIV_19K2        14'(`MSS_CLOCK_HZ / `MSS_BAUD_19K2)
`define MSS_DIV_9600        14'(`MSS_CLOCK_HZ / `MSS_BAUD_9600)
`define MSS_DIV_4800        14'(`MSS_CLOCK_HZ / `MSS_BAUD_4800)
`define MSS_DIV_RESET       14'(`MSS_CLOCK_HZ / `MSS_BAUD_9600)

`endif

// File: core/mss_pkg.sv
// Types for the serial setup and status front end
package mss_pkg;

  // ----------------------------------------------------------------
  // Setup enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSS_PARITY_NONE,
    MSS_PARITY_ODD,
    MSS_PARITY_EVEN,
    MSS_PARITY_BAD
  } mss_parity_e;

  typedef enum logic {
    MSS_FRAME_RTU,
    MSS_FRAME_ASCII
  } mss_frame_e;

  typedef logic [13:0] mss_div_t;

endpackage : mss_pkg

// File: core/mss_hold_timer.sv
// Retriggerable hold timer that keeps a level up for a set number of cycles
`timescale 1ns/1ps

module mss_hold_timer #(
  parameter int unsigned HOLD_CYCLES = 32'd400000000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Trigger and level
  input  wire logic trigger,
  output logic      active
);

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        active_reg;

  // A new trigger reloads, so steady traffic keeps the level up
  always_comb begin
    if (trigger) begin
      count_next = HOLD_CYCLES - 32'd1;
    end else if (count_reg != 32'd0) begin
      count_next = count_reg - 32'd1;
    end else begin
      count_next = 32'd0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= 32'd0;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= trigger | (count_reg != 32'd0);
    end
  end

  assign active = active_reg;

endmodule : mss_hold_timer

// File: test/mss_master_model.sv
// Far-side station model that delivers characters onto the receive path
`timescale 1ns/1ps

module mss_master_model (
  // Clock
  input  wire logic clock,
  // Receive path events
  output logic      rx_busy,
  output logic      rx_char_done
);
  initial begin
    rx_busy      = 1'b0;
    rx_char_done = 1'b0;
  end

  // ----------------------------------------------------------------
  // Character delivery, changed on falling edges only
  // ----------------------------------------------------------------
  task automatic start_char();
    rx_busy = 1'b1;
  endtask : start_char

  // Busy drops with the done pulse, so the pulse edge samples busy low
  task automatic finish_char();
    rx_busy      = 1'b0;
    rx_char_done = 1'b1;
    @(posedge clock);
    @(negedge clock);
    rx_char_done = 1'b0;
  endtask : finish_char
endmodule : mss_master_model

// File: test/mss_setup_status_tb_top.sv
// Self-checking bench for the serial setup and status front end
`timescale 1ns/1ps
`include "mss_params.svh"

module mss_setup_status_tb_top;
  localparam int unsigned HOLD = 20;
  localparam logic [13:0] D38 = 14'(`MSS_CLOCK_HZ / `MSS_BAUD_38K4);
  localparam logic [13:0] D19 = 14'(`MSS_CLOCK_HZ / `MSS_BAUD_19K2);
  localparam logic [13:0] D96 = 14'(`MSS_CLOCK_HZ / `MSS_BAUD_9600);
  localparam logic [13:0] D48 = 14'(`MSS_CLOCK_HZ / `MSS_BAUD_4800);

  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic [7:0]           addr_switch = 8'h00;
  logic [5:0]           dip_switch = 6'h00;
  logic [4:0]           err_vec = 5'h00;
  logic                 fault_clear = 1'b0;
  logic                 tx_busy = 1'b0;
  logic                 rx_busy;
  logic                 rx_char_done;
  logic [7:0]           node_addr_reg;
  logic                 addr_valid_reg;
  mss_pkg::mss_div_t    baud_div_reg;
  logic                 baud_valid_reg;
  mss_pkg::mss_parity_e parity_mode_reg;
  logic                 parity_valid_reg;
  mss_pkg::mss_frame_e  frame_mode_reg;
  logic                 alive_led_reg;
  logic                 fault_led_reg;
  logic                 transmit_activity_indicator_reg;
  logic                 rx_led_reg;
  int                   err_total = 0;
  int                   comparisons = 0;
  int                   cycles = 0;

  always #12.5 clock = ~clock;

  mss_master_model i_mss_master_model (.clock(clock), .rx_busy(rx_busy),
    .rx_char_done(rx_char_done));

  mss_setup_status #(.ALIVE_HOLD_CYCLES(HOLD)) i_mss_setup_status (
    .clock(clock), .rst(rst), .addr_switch(addr_switch), .dip_switch(dip_switch),
    .rx_char_done(rx_char_done), .rx_busy(rx_busy), .tx_busy(tx_busy),
    .parity_error(err_vec[0]), .framing_error(err_vec[1]), .overrun_error(err_vec[2]),
    .crc_error(err_vec[3]), .lrc_error(err_vec[4]), .fault_clear(fault_clear),
    .node_addr_reg(node_addr_reg), .addr_valid_reg(addr_valid_reg),
    .baud_div_reg(baud_div_reg), .baud_valid_reg(baud_valid_reg),
    .parity_mode_reg(parity_mode_reg), .parity_valid_reg(parity_valid_reg),
    .frame_mode_reg(frame_mode_reg), .alive_led_reg(alive_led_reg),
    .fault_led_reg(fault_led_reg),
    .transmit_activity_indicator_reg(transmit_activity_indicator_reg),
    .rx_led_reg(rx_led_reg));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : tick

  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string name, input logic [13:0] exp, input logic [13:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Ceiling well above the roughly 125 cycles the scenarios need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk_val("node_addr", 14'h0000, 14'(node_addr_reg));
    chk_bit("addr_valid", 1'b0, addr_valid_reg);
    chk_val("baud_div", D96, baud_div_reg);
    chk_bit("baud_valid", 1'b0, baud_valid_reg);
    chk_val("parity", 14'(mss_pkg::MSS_PARITY_NONE), 14'(parity_mode_reg));
    chk_bit("parity_valid", 1'b0, parity_valid_reg);
    chk_val("frame", 14'(mss_pkg::MSS_FRAME_RTU), 14'(frame_mode_reg));
    chk_val("leds", 14'h0000, 14'({alive_led_reg, fault_led_reg,
      transmit_activity_indicator_reg, rx_led_reg}));
  endtask : test_reset

  // Both range edges and their outside neighbours
  task automatic test_addr();
    logic [7:0] tbl [5];
    tbl = '{8'h00, 8'h01, 8'hf7, 8'hf8, 8'hff};
    foreach (tbl[i]) begin
      addr_switch = tbl[i];
      tick(1);
      chk_val("node_addr", 14'(tbl[i]), 14'(node_addr_reg));
      chk_bit("addr_valid", tbl[i] >= 8'h01 && tbl[i] <= 8'hf7, addr_valid_reg);
    end
  endtask : test_addr

  // Every switch pattern, so each rate, parity and framing code is set
  task automatic test_dip();
    logic [13:0]          ediv;
    logic                 evalid;
    mss_pkg::mss_parity_e epar;
    for (int i = 0; i < 64; i++) begin
      dip_switch = 6'(i);
      tick(1);
      evalid = 1'b1;
      case (dip_switch[2:0])
        3'h3: ediv = D38;
        3'h2: ediv = D19;
        3'h1: ediv = D96;
        3'h0: ediv = D48;
        default: begin
          ediv   = D96;
          evalid = 1'b0;
        end
      endcase
      case ({dip_switch[3], dip_switch[4]})
        2'h3: epar = mss_pkg::MSS_PARITY_NONE;
        2'h1: epar = mss_pkg::MSS_PARITY_ODD;
        2'h2: epar = mss_pkg::MSS_PARITY_EVEN;
        default: epar = mss_pkg::MSS_PARITY_BAD;
      endcase
      chk_val("baud_div", ediv, baud_div_reg);
      chk_bit("baud_valid", evalid, baud_valid_reg);
      chk_val("parity", 14'(epar), 14'(parity_mode_reg));
      chk_bit("parity_valid", epar != mss_pkg::MSS_PARITY_BAD, parity_valid_reg);
      chk_val("frame", dip_switch[5] ? 14'(mss_pkg::MSS_FRAME_RTU) :
        14'(mss_pkg::MSS_FRAME_ASCII), 14'(frame_mode_reg));
    end
  endtask : test_dip

  // Second character must push the alive hold past the first one's expiry
  task automatic test_alive();
    i_mss_master_model.start_char();
    tick(1);
    chk_bit("rx_led", 1'b1, rx_led_reg);
    i_mss_master_model.finish_char();
    chk_bit("rx_led", 1'b0, rx_led_reg);
    tick(1);
    chk_bit("alive_led", 1'b1, alive_led_reg);
    tick(8);
    i_mss_master_model.start_char();
    tick(1);
    i_mss_master_model.finish_char();
    tick(HOLD - 1);
    chk_bit("alive_led", 1'b1, alive_led_reg);
    tick(1);
    chk_bit("alive_led", 1'b1, alive_led_reg);
    tick(1);
    chk_bit("alive_led", 1'b0, alive_led_reg);
  endtask : test_alive

  // Each error source sets the sticky fault; clear loses to a live error
  task automatic test_fault();
    for (int i = 0; i < 5; i++) begin
      err_vec = 5'h01 << i;
      tick(1);
      chk_bit("fault_led", 1'b1, fault_led_reg);
      fault_clear = 1'b1;
      tick(1);
      chk_bit("fault_led", 1'b1, fault_led_reg);
      err_vec = 5'h00;
      tick(1);
      chk_bit("fault_led", 1'b0, fault_led_reg);
      fault_clear = 1'b0;
    end
  endtask : test_fault

  task automatic test_tx();
    tx_busy = 1'b1;
    tick(1);
    chk_bit("tx_led", 1'b1, transmit_activity_indicator_reg);
    tick(2);
    chk_bit("tx_led", 1'b1, transmit_activity_indicator_reg);
    tx_busy = 1'b0;
    tick(1);
    chk_bit("tx_led", 1'b0, transmit_activity_indicator_reg);
  endtask : test_tx

  initial begin
    tick(1);
    test_reset();
    @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    test_addr();
    test_dip();
    test_alive();
    test_fault();
    test_tx();
    wrap_up();
  end
endmodule : mss_setup_status_tb_top
